// file: rtl/dpk_access.sv
// Key-protected access layer of the single pin debug port.
// Assumes the link layer delivers key bytes, control writes and bus requests
// as one-cycle strobes synchronous to i_mclk, which never stops.
// Summary of operation
// [R1] Three 64-bit keys, low byte first.
// [R2] Later erase key keeps programming key.
// [R3] Programming key: unlocked, active; drops when done.
// [R4] Row key: locked part; dropped by write.
// [R5] Key status shows each activated key.
// [R6] Reset signature holds reset until zero.
// [R7] Lock state reads 0 when erase finished.
// [R8] Locked part refuses system bus accesses.
// [R9] Erase forces brownout on, fuse level.
// [R10] Programming active reported after reset pulse.
// [R11] Row mode accepts writes below 32 only.
// [R12] Row buffer copied one to one.
// [R13] Write-final triggers copy, clears row status.
// [R14] Debugger clears row key, pulses reset.
// [R15] Row mode returns no SRAM read data.
// [R16] Event per sync character rising edge.
// [R17] Port logic runs in every sleep.
// [R18] Deep sleep without clock hold blocks reads.
// [R19] Asleep status set at idle or deeper.
// [R20] Clock hold resets to 1, keeps clock.
// [R21] Key status set only on exact match.
`timescale 1ns/1ps
module dpk_access #(
  parameter int          ROW_DEPTH       = 32,
  parameter logic [7:0]  RESET_SIGNATURE = 8'h59  // Arbitrary default value.
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_port_reset,
  input  wire logic        i_key_start,
  input  wire logic        i_key_byte_vld,
  input  wire logic [7:0]  i_key_byte,
  input  wire logic        i_rst_req_wr,
  input  wire logic [7:0]  i_rst_req_data,
  input  wire logic        i_key_status_wr,
  input  wire logic [7:0]  i_key_status_data,
  input  wire logic        i_ctrl_wr,
  input  wire logic        i_ctrl_clock_hold,
  input  wire logic        i_ctrl_write_final,
  input  wire logic        i_lock_bits,
  input  wire logic        i_erase_done,
  input  wire logic        i_prog_done,
  input  wire logic [1:0]  i_sleep_mode,
  input  wire logic [1:0]  i_fuse_bod_level,
  input  wire logic        i_sync_rise,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_write,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_wdata,
  input  wire logic [7:0]  i_bus_rdata_sys,
  input  wire logic        i_row_ack,
  output logic [7:0]       o_key_status,
  output logic             o_sys_reset,
  output logic             o_erase_start,
  output logic             o_lock_state,
  output logic             o_prog_active,
  output logic             o_row_prog_active,
  output logic             o_system_asleep,
  output logic             o_clock_hold_request,
  output logic             o_bod_force,
  output logic [1:0]       o_bod_mode,
  output logic [1:0]       o_bod_level,
  output logic             o_sync_event,
  output logic             o_bus_grant,
  output logic [7:0]       o_bus_rdata,
  output logic             o_row_wr,
  output logic [4:0]       o_row_addr,
  output logic [7:0]       o_row_data,
  output logic             o_access_reject
);
  if (ROW_DEPTH != 32) begin : g_depth_check
    $error("dpk_access supports a 32-byte row only");
  end
  // ==========================================================================
  // Key reception
  logic [63:0] key_word;
  logic        key_done;
  dpk_key_shift #(.KEY_BYTES(8)) u_shift (
    .i_mclk     (i_mclk),
    .i_reset_n  (i_reset_n),
    .i_start    (i_key_start),
    .i_byte_vld (i_key_byte_vld),
    .i_byte     (i_key_byte),
    .o_key      (key_word),
    .o_key_done (key_done)
  );
  logic hit_erase;
  logic hit_prog;
  logic hit_row;
  assign hit_erase = key_done && (key_word == dpk_pkg::KEY_ERASE);   // [R1] [R21]
  assign hit_prog  = key_done && (key_word == dpk_pkg::KEY_MEMPROG); // [R1] [R21]
  assign hit_row   = key_done && (key_word == dpk_pkg::KEY_ROW);     // [R1] [R21]
  // ==========================================================================
  // Key status
  logic key_erase_ff;
  logic key_prog_ff;
  logic key_row_ff;
  logic row_key_clr;
  assign row_key_clr = i_key_status_wr && i_key_status_data[dpk_pkg::KS_ROW_BIT];
  logic erase_busy_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_erase_ff <= 1'b0;
    end else if (hit_erase) begin
      key_erase_ff <= 1'b1;
    end else if (i_port_reset || (erase_busy_ff && i_erase_done)) begin
      key_erase_ff <= 1'b0;
    end
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_prog_ff <= 1'b0;
    end else if (hit_prog) begin
      key_prog_ff <= 1'b1;                                           // [R2]
    end else if (i_port_reset || i_prog_done) begin
      key_prog_ff <= 1'b0;                                           // [R3]
    end
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_row_ff <= 1'b0;
    end else if (hit_row) begin
      key_row_ff <= 1'b1;
    end else if (i_port_reset || row_key_clr) begin
      key_row_ff <= 1'b0;                                            // [R4] [R14]
    end
  end
  always_comb begin
    o_key_status = 8'h00;
    o_key_status[dpk_pkg::KS_ERASE_BIT]   = key_erase_ff;            // [R5]
    o_key_status[dpk_pkg::KS_MEMPROG_BIT] = key_prog_ff;             // [R5]
    o_key_status[dpk_pkg::KS_ROW_BIT]     = key_row_ff;              // [R5]
  end
  // ==========================================================================
  // Reset request
  logic sys_reset_ff;
  logic rst_fall;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_reset_ff <= 1'b0;
    end else if (i_rst_req_wr) begin
      if (i_rst_req_data == RESET_SIGNATURE) begin
        sys_reset_ff <= 1'b1;                                        // [R6]
      end else if (i_rst_req_data == dpk_pkg::RST_RELEASE) begin
        sys_reset_ff <= 1'b0;                                        // [R6]
      end
    end
  end
  assign rst_fall    = sys_reset_ff && i_rst_req_wr && (i_rst_req_data == dpk_pkg::RST_RELEASE);
  assign o_sys_reset = sys_reset_ff;
  // ==========================================================================
  // Erase and brownout force
  logic erase_start_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      erase_busy_ff  <= 1'b0;
      erase_start_ff <= 1'b0;
    end else begin
      erase_start_ff <= rst_fall && key_erase_ff;
      if (rst_fall && key_erase_ff) begin
        erase_busy_ff <= 1'b1;
      end else if (i_erase_done) begin
        erase_busy_ff <= 1'b0;
      end
    end
  end
  assign o_erase_start = erase_start_ff;
  assign o_lock_state  = i_lock_bits || erase_busy_ff;               // [R7]
  assign o_bod_force   = erase_busy_ff;                              // [R9]
  assign o_bod_mode    = erase_busy_ff ? dpk_pkg::BOD_MODE_ON : 2'h0; // [R9]
  assign o_bod_level   = i_fuse_bod_level;                           // [R9]
  // ==========================================================================
  // Programming mode
  logic prog_active_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prog_active_ff <= 1'b0;
    end else if (i_port_reset || i_prog_done || !key_prog_ff) begin
      prog_active_ff <= 1'b0;
    end else if (rst_fall && !i_lock_bits) begin
      prog_active_ff <= 1'b1;                                        // [R3] [R10]
    end
  end
  assign o_prog_active = prog_active_ff;
  // ==========================================================================
  // Configuration row programming
  dpk_pkg::dpk_row_state_type row_st_ff;
  logic [4:0] copy_idx_ff;
  logic [7:0] row_buf_ff [ROW_DEPTH];
  logic       row_fill;
  logic       row_wr_ok;
  assign row_fill  = (row_st_ff == dpk_pkg::DPK_ROW_FILL);
  assign row_wr_ok = row_fill && i_bus_req && i_bus_write
                     && (i_bus_addr < 16'(dpk_pkg::ROW_BYTES));      // [R11]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      row_st_ff   <= dpk_pkg::DPK_ROW_IDLE;
      copy_idx_ff <= 5'h00;
    end else if (i_port_reset || !key_row_ff) begin
      row_st_ff   <= dpk_pkg::DPK_ROW_IDLE;
      copy_idx_ff <= 5'h00;
    end else begin
      case (row_st_ff)
        dpk_pkg::DPK_ROW_IDLE: begin
          if (rst_fall && i_lock_bits) begin
            row_st_ff <= dpk_pkg::DPK_ROW_FILL;                      // [R4]
          end
        end
        dpk_pkg::DPK_ROW_FILL: begin
          if (i_ctrl_wr && i_ctrl_write_final) begin
            row_st_ff   <= dpk_pkg::DPK_ROW_COPY;                    // [R13]
            copy_idx_ff <= 5'h00;
          end
        end
        dpk_pkg::DPK_ROW_COPY: begin
          if (i_row_ack) begin
            if (copy_idx_ff == 5'(ROW_DEPTH - 1)) begin
              row_st_ff <= dpk_pkg::DPK_ROW_DONE;                    // [R13]
            end else begin
              copy_idx_ff <= copy_idx_ff + 5'h01;                    // [R12]
            end
          end
        end
        dpk_pkg::DPK_ROW_DONE: begin
          row_st_ff <= dpk_pkg::DPK_ROW_DONE;
        end
        default: begin
          row_st_ff <= dpk_pkg::DPK_ROW_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < ROW_DEPTH; i++) begin
        row_buf_ff[i] <= 8'hFF;
      end
    end else if (row_wr_ok) begin
      row_buf_ff[i_bus_addr[4:0]] <= i_bus_wdata;                    // [R11]
    end
  end
  logic       row_wr_ff;
  logic [4:0] row_addr_ff;
  logic [7:0] row_data_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      row_wr_ff   <= 1'b0;
      row_addr_ff <= 5'h00;
      row_data_ff <= 8'h00;
    end else begin
      row_wr_ff   <= (row_st_ff == dpk_pkg::DPK_ROW_COPY) && !i_row_ack;
      row_addr_ff <= copy_idx_ff;                                    // [R12]
      row_data_ff <= row_buf_ff[copy_idx_ff];                        // [R12]
    end
  end
  assign o_row_wr          = row_wr_ff;
  assign o_row_addr        = row_addr_ff;
  assign o_row_data        = row_data_ff;
  assign o_row_prog_active = row_fill || (row_st_ff == dpk_pkg::DPK_ROW_COPY); // [R13]
  // ==========================================================================
  // Sleep, clock hold and system bus gating
  logic clk_hold_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_hold_ff <= dpk_pkg::CLK_HOLD_RST;                          // [R20]
    end else if (i_ctrl_wr) begin
      clk_hold_ff <= i_ctrl_clock_hold;
    end
  end
  assign o_clock_hold_request = clk_hold_ff;                         // [R20]
  assign o_system_asleep = (i_sleep_mode >= dpk_pkg::SLEEP_IDLE);    // [R19]
  // The port logic uses the sleep input only to gate bus grants and report asleep status, so it keeps running in every mode.
  logic sleep_block;
  assign sleep_block = (i_sleep_mode >= dpk_pkg::SLEEP_DEEP) && !clk_hold_ff; // [R17] [R18]
  logic grant;
  always_comb begin
    grant = i_bus_req;
    if (row_fill || (row_st_ff == dpk_pkg::DPK_ROW_COPY)) begin
      grant = 1'b0;                                                  // [R15]
    end else if (i_lock_bits || erase_busy_ff) begin
      grant = 1'b0;                                                  // [R8]
    end else if (sleep_block) begin
      grant = 1'b0;                                                  // [R18]
    end
  end
  assign o_bus_grant     = grant;
  assign o_access_reject = i_bus_req && !grant && !row_wr_ok;
  logic [7:0] rdata_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= 8'h00;
    end else if (i_bus_req && !i_bus_write) begin
      rdata_ff <= grant ? i_bus_rdata_sys : 8'h00;                   // [R15]
    end
  end
  assign o_bus_rdata = rdata_ff;
  // ==========================================================================
  // Sync edge event, never disabled.
  logic sync_ev_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_ev_ff <= 1'b0;
    end else begin
      sync_ev_ff <= i_sync_rise;                                     // [R16]
    end
  end
  assign o_sync_event = sync_ev_ff;
  // ==========================================================================
  // Assertions
  sequence s_rst_written;
    i_rst_req_wr && (i_rst_req_data == RESET_SIGNATURE);
  endsequence
  AST_RESET_HOLD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_rst_written |=> o_sys_reset) else $error("reset not asserted");  // [R6]
  AST_RESET_STAYS: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_sys_reset && !i_rst_req_wr |=> o_sys_reset) else $error("reset released early"); // [R6]
  AST_KEY_MATCH: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(key_prog_ff) |-> $past(key_word) == dpk_pkg::KEY_MEMPROG) else $error("bad key set"); // [R21]
  AST_PROG_KEEP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    key_prog_ff && hit_erase |=> key_prog_ff) else $error("erase key dropped prog key"); // [R2]
  AST_LOCK_REFUSE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_lock_bits |-> !o_bus_grant) else $error("grant while locked");  // [R8]
  AST_BOD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    erase_busy_ff |-> o_bod_force && o_bod_mode == 2'h1) else $error("brownout not forced"); // [R9]
  AST_ASLEEP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_system_asleep == (i_sleep_mode != 2'h0)) else $error("asleep wrong"); // [R19]
  AST_SLEEP_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_sleep_mode >= 2'h2 && !o_clock_hold_request |-> !o_bus_grant) else $error("grant in sleep"); // [R18]
  AST_SYNC_EVENT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_sync_rise |=> o_sync_event) else $error("sync event missing"); // [R16]
  AST_ROW_RANGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    row_wr_ok |-> i_bus_addr < 16'h0020) else $error("row write out of range"); // [R11]
  AST_ROW_NOREAD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_row_prog_active && i_bus_req && !i_bus_write |=> o_bus_rdata == 8'h00)
    else $error("sram read in row mode"); // [R15]
endmodule : dpk_access

// file: rtl/dpk_pkg.sv
// Package for the debug port key unlock access block.
// Assumes a single 125 MHz clock domain and byte-wide control/status writes.
package dpk_pkg;
  // ==========================================================================
  // Key signatures
  localparam logic [63:0] KEY_ERASE      = 64'h4E564D4572617365;
  localparam logic [63:0] KEY_MEMPROG    = 64'h4E564D50726F6720;
  localparam logic [63:0] KEY_ROW        = 64'h4E564D5573267465;
  // ==========================================================================
  // Key status bit positions
  localparam int          KS_ERASE_BIT   = 3;
  localparam int          KS_MEMPROG_BIT = 4;
  localparam int          KS_ROW_BIT     = 5;
  // ==========================================================================
  // Reset request, brownout, row size, clock hold
  localparam logic [7:0]  RST_RELEASE    = 8'h00;
  localparam logic [1:0]  BOD_MODE_ON    = 2'h1;
  localparam logic [5:0]  ROW_BYTES      = 6'h20;
  localparam logic        CLK_HOLD_RST   = 1'b1;
  // ==========================================================================
  // Sleep modes: 0 active, 1 idle, higher values deeper.
  localparam logic [1:0]  SLEEP_IDLE     = 2'h1;
  localparam logic [1:0]  SLEEP_DEEP     = 2'h2;
  typedef enum logic [1:0] {
    DPK_ROW_IDLE  = 2'b00,
    DPK_ROW_FILL  = 2'b01,
    DPK_ROW_COPY  = 2'b10,
    DPK_ROW_DONE  = 2'b11
  } dpk_row_state_type;
endpackage : dpk_pkg

// file: rtl/dpk_key_shift.sv
// Key shift register: collects 64 key bits arriving as bytes, low byte first.
// Assumes i_byte_vld pulses once per key byte.
`timescale 1ns/1ps
module dpk_key_shift #(
  parameter int KEY_BYTES = 8
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_start,
  input  wire logic                   i_byte_vld,
  input  wire logic [7:0]             i_byte,
  output logic [KEY_BYTES*8-1:0]      o_key,
  output logic                        o_key_done
);
  if (KEY_BYTES != 8) begin : g_width_check
    $error("dpk_key_shift supports 64-bit keys only");
  end
  logic [KEY_BYTES*8-1:0] key_ff;
  logic [3:0]             cnt_ff;
  logic                   done_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_ff  <= '0;
      cnt_ff  <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (i_start) begin
        cnt_ff <= 4'h0;
      end else if (i_byte_vld) begin
        // Low byte arrives first, so shift new bytes in from the top.
        key_ff <= {i_byte, key_ff[KEY_BYTES*8-1:8]};
        if (cnt_ff == 4'(KEY_BYTES - 1)) begin
          cnt_ff  <= 4'h0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
  assign o_key      = key_ff;
  assign o_key_done = done_ff;
endmodule : dpk_key_shift

// file: testbench/dpk_dbg_model.sv
// Debugger model: key transfers and control/status register writes of the port.
// Assumes callers share the bench clock; every strobe moves at the falling edge.
`timescale 1ns/1ps
module dpk_dbg_model (
  input  wire logic  i_mclk,
  output logic       o_key_start,
  output logic       o_key_vld,
  output logic [7:0] o_key_byte,
  output logic       o_rst_wr,
  output logic [7:0] o_rst_data,
  output logic       o_ks_wr,
  output logic [7:0] o_ks_data,
  output logic       o_ctrl_wr,
  output logic       o_hold,
  output logic       o_final
);
  initial begin
    {o_key_start, o_key_vld, o_rst_wr, o_ks_wr, o_ctrl_wr, o_final} = '0;
    {o_key_byte, o_rst_data, o_ks_data} = '0;
    o_hold = 1'b1;
  end
  // ==========================================================================
  // Key transfer
  task automatic send_key(input logic [63:0] key);
    @(negedge i_mclk);
    o_key_start <= 1'b1;
    @(negedge i_mclk);
    o_key_start <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      o_key_vld  <= 1'b1;
      o_key_byte <= key[i*8 +: 8];
      @(negedge i_mclk);
    end
    o_key_vld  <= 1'b0;
    // Released data is inverted so a stale byte can never pass as a fresh one.
    o_key_byte <= ~key[63:56];
  endtask : send_key
  // ==========================================================================
  // Register writes, one-cycle strobes
  task automatic wr_rst(input logic [7:0] d);
    @(negedge i_mclk);
    o_rst_wr   <= 1'b1;
    o_rst_data <= d;
    @(negedge i_mclk);
    o_rst_wr   <= 1'b0;
    o_rst_data <= ~d;
  endtask : wr_rst
  task automatic wr_ks(input logic [7:0] d);
    @(negedge i_mclk);
    o_ks_wr   <= 1'b1;
    o_ks_data <= d;
    @(negedge i_mclk);
    o_ks_wr   <= 1'b0;
    o_ks_data <= ~d;
  endtask : wr_ks
  task automatic wr_ctrl(input logic hold, input logic fin);
    @(negedge i_mclk);
    o_ctrl_wr <= 1'b1;
    o_hold    <= hold;
    o_final   <= fin;
    @(negedge i_mclk);
    o_ctrl_wr <= 1'b0;
    o_final   <= ~fin;
  endtask : wr_ctrl
endmodule : dpk_dbg_model

// file: testbench/dpk_access_tb.sv
// Self-checking bench for the key-protected access block.
// Assumes the design package and the debugger model are compiled first.
`timescale 1ns/1ps
module dpk_access_tb;
  localparam logic [7:0] SIG = 8'h59; // Arbitrary reset signature.
  logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_port_reset = 1'b0;
  logic        i_key_start, i_key_byte_vld, i_rst_req_wr, i_key_status_wr, i_ctrl_wr, i_ctrl_clock_hold;
  logic        i_ctrl_write_final, i_lock_bits, i_erase_done, i_prog_done, i_sync_rise, i_bus_req;
  logic        i_bus_write, i_row_ack, o_sys_reset, o_erase_start, o_lock_state, o_prog_active;
  logic        o_row_prog_active, o_system_asleep, o_clock_hold_request, o_bod_force, o_sync_event;
  logic        o_bus_grant, o_row_wr, o_access_reject, g, es;
  logic [7:0]  i_key_byte, i_rst_req_data, i_key_status_data, i_bus_wdata, i_bus_rdata_sys, rd;
  logic [7:0]  o_key_status, o_bus_rdata, o_row_data, d8;
  logic [1:0]  i_sleep_mode, i_fuse_bod_level, o_bod_mode, o_bod_level;
  logic [15:0] i_bus_addr;
  logic [4:0]  o_row_addr;
  logic [7:0]  exp_row [32];
  int          errors = 0, compares = 0, seed = 38, n;
  always #4 i_mclk = ~i_mclk;
  dpk_dbg_model dbg (.i_mclk, .o_key_start(i_key_start), .o_key_vld(i_key_byte_vld), .o_key_byte(i_key_byte),
    .o_rst_wr(i_rst_req_wr), .o_rst_data(i_rst_req_data), .o_ks_wr(i_key_status_wr),
    .o_ks_data(i_key_status_data), .o_ctrl_wr(i_ctrl_wr), .o_hold(i_ctrl_clock_hold),
    .o_final(i_ctrl_write_final));
  dpk_access #(.ROW_DEPTH(32), .RESET_SIGNATURE(SIG)) DUT (.i_mclk, .i_reset_n, .i_port_reset, .i_key_start,
    .i_key_byte_vld, .i_key_byte, .i_rst_req_wr, .i_rst_req_data, .i_key_status_wr, .i_key_status_data,
    .i_ctrl_wr, .i_ctrl_clock_hold, .i_ctrl_write_final, .i_lock_bits, .i_erase_done, .i_prog_done,
    .i_sleep_mode, .i_fuse_bod_level, .i_sync_rise, .i_bus_req, .i_bus_write, .i_bus_addr, .i_bus_wdata,
    .i_bus_rdata_sys, .i_row_ack, .o_key_status, .o_sys_reset, .o_erase_start, .o_lock_state,
    .o_prog_active, .o_row_prog_active, .o_system_asleep, .o_clock_hold_request, .o_bod_force, .o_bod_mode,
    .o_bod_level, .o_sync_event, .o_bus_grant, .o_bus_rdata, .o_row_wr, .o_row_addr, .o_row_data,
    .o_access_reject);
  // ==========================================================================
  // Reporting
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check_byte
  task automatic check_bit(input string nm, input logic e, input logic s);
    check_byte(nm, {7'h00, e}, {7'h00, s});
  endtask : check_bit
  // A wait that used up its bound ends the run at once.
  task automatic bound(input int cnt);
    if (cnt >= 200) begin
      errors++;
      $display("[FAIL] wait expected under 200 seen %0d", cnt);
      test_done();
    end
  endtask : bound
  // ==========================================================================
  // Bus request and reset pulse
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_bus_req   <= 1'b1;
    i_bus_write <= w;
    i_bus_addr  <= a;
    i_bus_wdata <= d;
    #1 g = o_bus_grant;
    check_bit("reject", ~g & ~(o_row_prog_active & w & (a < 16'h0020)), o_access_reject);
    @(negedge i_mclk);
    i_bus_req   <= 1'b0;
    i_bus_addr  <= ~a;
    rd = o_bus_rdata;
  endtask : bus
  task automatic pulse_reset(output logic start);
    dbg.wr_rst(SIG);
    repeat (3) @(negedge i_mclk);
    check_bit("sys_reset held", 1'b1, o_sys_reset);
    dbg.wr_rst(8'h00);
    for (n = 0; n < 3 && o_sys_reset !== 1'b0; n++) @(negedge i_mclk);
    check_bit("sys_reset released", 1'b0, o_sys_reset);
    start = o_erase_start;
  endtask : pulse_reset
  // ==========================================================================
  // Main sequence
  initial begin
    {i_erase_done, i_prog_done, i_sync_rise, i_bus_req, i_bus_write, i_row_ack} = '0;
    i_sleep_mode = 2'h0;
    i_fuse_bod_level = 2'($random(seed));
    i_bus_addr = 16'h0000;
    i_bus_wdata = 8'h00;
    i_bus_rdata_sys = 8'($random(seed)) | 8'h01;
    i_lock_bits = 1'b1;
    repeat (8) @(negedge i_mclk);
    i_reset_n = 1'b1;
    check_bit("hold at reset", 1'b1, o_clock_hold_request);
    check_byte("keys at reset", 8'h00, o_key_status);
    for (int k = 0; k < 3; k++) begin
      i_sync_rise <= 1'b1;
      @(negedge i_mclk);
      i_sync_rise <= 1'b0;
      check_bit("sync event", 1'b1, o_sync_event);
      @(negedge i_mclk);
      check_bit("sync event end", 1'b0, o_sync_event);
    end
    // A near miss in the lowest bit must be refused like a random key.
    dbg.send_key(dpk_pkg::KEY_ERASE ^ 64'h1);
    dbg.send_key({$random(seed), $random(seed)});
    repeat (3) @(negedge i_mclk);
    check_byte("bad keys", 8'h00, o_key_status);
    dbg.send_key(dpk_pkg::KEY_ERASE);
    for (n = 0; n < 200 && o_key_status === 8'h00; n++) @(negedge i_mclk);
    bound(n);
    check_byte("erase key", 8'(1 << dpk_pkg::KS_ERASE_BIT), o_key_status);
    pulse_reset(es);
    check_bit("erase start", 1'b1, es);
    check_bit("lock busy", 1'b1, o_lock_state);
    check_bit("bod force", 1'b1, o_bod_force);
    check_byte("bod mode", {6'h00, dpk_pkg::BOD_MODE_ON}, {6'h00, o_bod_mode});
    check_byte("bod level", {6'h00, i_fuse_bod_level}, {6'h00, o_bod_level});
    bus(1'b0, 16'h0010, 8'h00);
    check_bit("locked grant", 1'b0, g);
    i_erase_done <= 1'b1;
    i_lock_bits  <= 1'b0;
    @(negedge i_mclk);
    i_erase_done <= 1'b0;
    for (n = 0; n < 200 && o_lock_state !== 1'b0; n++) @(negedge i_mclk);
    bound(n);
    check_bit("bod released", 1'b0, o_bod_force);
    bus(1'b0, 16'h0010, 8'h00);
    check_bit("open grant", 1'b1, g);
    check_byte("read data", i_bus_rdata_sys, rd);
    dbg.send_key(dpk_pkg::KEY_MEMPROG);
    dbg.send_key(dpk_pkg::KEY_ERASE);
    repeat (3) @(negedge i_mclk);
    check_bit("prog key kept", 1'b1, o_key_status[dpk_pkg::KS_MEMPROG_BIT]);
    i_port_reset <= 1'b1;
    @(negedge i_mclk);
    i_port_reset <= 1'b0;
    @(negedge i_mclk);
    check_byte("port reset", 8'h00, o_key_status);
    dbg.send_key(dpk_pkg::KEY_MEMPROG);
    pulse_reset(es);
    check_bit("no erase", 1'b0, es);
    for (n = 0; n < 200 && o_prog_active !== 1'b1; n++) @(negedge i_mclk);
    bound(n);
    bus(1'b1, 16'h1000, 8'($random(seed)));
    check_bit("prog grant", 1'b1, g);
    for (int m = 0; m < 4; m++) begin
      i_sleep_mode <= 2'(m);
      @(negedge i_mclk);
      check_bit("asleep", m != 0, o_system_asleep);
    end
    bus(1'b0, 16'h0040, 8'h00);
    check_bit("held clock grant", 1'b1, g);
    dbg.wr_ctrl(1'b0, 1'b0);
    check_bit("hold cleared", 1'b0, o_clock_hold_request);
    bus(1'b0, 16'h0040, 8'h00);
    check_bit("deep sleep grant", 1'b0, g);
    i_sleep_mode <= dpk_pkg::SLEEP_IDLE;
    bus(1'b0, 16'h0040, 8'h00);
    check_bit("idle grant", 1'b1, g);
    i_sleep_mode <= 2'h0;
    dbg.wr_ctrl(1'b1, 1'b0);
    i_prog_done <= 1'b1;
    @(negedge i_mclk);
    i_prog_done <= 1'b0;
    repeat (2) @(negedge i_mclk);
    check_bit("prog done", 1'b0, o_prog_active);
    check_byte("prog key dropped", 8'h00, o_key_status);
    i_lock_bits <= 1'b1;
    dbg.send_key(dpk_pkg::KEY_ROW);
    for (n = 0; n < 200 && o_key_status === 8'h00; n++) @(negedge i_mclk);
    bound(n);
    check_byte("row key", 8'(1 << dpk_pkg::KS_ROW_BIT), o_key_status);
    pulse_reset(es);
    for (n = 0; n < 200 && o_row_prog_active !== 1'b1; n++) @(negedge i_mclk);
    bound(n);
    check_bit("locked prog", 1'b0, o_prog_active);
    // Two writes past the window, both aliasing address zero, must be dropped.
    for (int i = 0; i < 34; i++) begin
      d8 = 8'($random(seed));
      if (i < 32) exp_row[i] = d8;
      bus(1'b1, (i < 32) ? 16'(i) : ((i == 32) ? 16'h0020 : 16'h0100), d8);
    end
    bus(1'b0, 16'h0003, 8'h00);
    check_byte("row mode read", 8'h00, rd);
    dbg.wr_ctrl(1'b1, 1'b1);
    for (int i = 0; i < 32; i++) begin
      for (n = 0; n < 200 && o_row_wr !== 1'b1; n++) @(negedge i_mclk);
      bound(n);
      // The far side stalls zero to two cycles (i % 3) before each acknowledge.
      repeat (i % 3) @(negedge i_mclk);
      check_byte("row addr", 8'(i), {3'h0, o_row_addr});
      check_byte("row data", exp_row[i], o_row_data);
      i_row_ack <= 1'b1;
      @(negedge i_mclk);
      i_row_ack <= 1'b0;
    end
    for (n = 0; n < 200 && o_row_prog_active !== 1'b0; n++) @(negedge i_mclk);
    bound(n);
    check_bit("row done", 1'b0, o_row_prog_active);
    dbg.wr_ks(8'(1 << dpk_pkg::KS_ROW_BIT));
    @(negedge i_mclk);
    check_byte("row key dropped", 8'h00, o_key_status);
    pulse_reset(es);
    test_done();
  end
endmodule : dpk_access_tb
